//--- core/iplr_consts.svh
// Register offsets, field positions, reset values and sizes for the
// priority level register bank. Assumes a byte-addressed 32-bit bus.
`ifndef IPLR_CONSTS_SVH
`define IPLR_CONSTS_SVH
`define IPLR_IDX_HIGH      8'hb7
`define IPLR_IDX_LOW       8'hb8
`define IPLR_ADDR_HIGH     10'h2dc
`define IPLR_ADDR_LOW      10'h2e0
`define IPLR_ADDR_STATUS   10'h300
`define IPLR_ADDR_CTRL     10'h304
`define IPLR_ADDR_W        10
`define IPLR_NSRC          6
`define IPLR_FIELD_W       6
`define IPLR_RESET_FIELD   6'h00
`define IPLR_RESET_CTRL    8'h00
`define IPLR_CTRL_RUN_BIT  0
`define IPLR_CTRL_RET_BIT  1
`define IPLR_NONE_ID       3'h7
`endif

//--- core/iplr_pkg.sv
// Types shared by the priority level register bank and its resolver.
// Assumes nothing beyond the constants header.
package iplr_pkg;
  typedef logic [1:0] iplr_level_t;
  typedef logic [2:0] iplr_src_t;
  typedef logic [5:0] iplr_vec_t;
  typedef enum logic [2:0] {
    IPLR_SRC_EXT0,
    IPLR_SRC_TMR0,
    IPLR_SRC_EXT1,
    IPLR_SRC_TMR1,
    IPLR_SRC_SERIAL,
    IPLR_SRC_TMR2
  } iplr_src_e;
endpackage

//--- core/iplr_sel_if.sv
// Bundle between the register bank and the resolver.
// Assumes both ends share core_clk.
interface iplr_sel_if;
  iplr_pkg::iplr_vec_t   high_bits;
  iplr_pkg::iplr_vec_t   low_bits;
  iplr_pkg::iplr_vec_t   pending;
  logic                  in_service;
  iplr_pkg::iplr_level_t active_level;
  logic                  grant;
  iplr_pkg::iplr_src_t   grant_src;
  iplr_pkg::iplr_level_t grant_level;
  modport bank (output high_bits, low_bits, pending, in_service,
                active_level, input grant, grant_src, grant_level);
  modport res (input high_bits, low_bits, pending, in_service,
               active_level, output grant, grant_src, grant_level);
endinterface

//--- core/iplr_resolver.sv
// Combinational level and order resolver for the six basic sources.
// Assumes pending requests already sampled on core_clk.
`include "iplr_consts.svh"
module iplr_resolver (
  iplr_sel_if.res sel
);
  function automatic iplr_pkg::iplr_level_t lvl_of(
    input iplr_pkg::iplr_vec_t hi,
    input iplr_pkg::iplr_vec_t lo,
    input int                  idx
  );
    lvl_of = {hi[idx], lo[idx]};
  endfunction

  always_comb
  begin
    sel.grant       = 1'b0;
    sel.grant_src   = `IPLR_NONE_ID;
    sel.grant_level = 2'h0;
    // Higher level first, lowest index wins within a level.
    for (int lv = 3; lv >= 0; lv--)
    begin
      for (int s = 0; s < `IPLR_NSRC; s++)
      begin
        if (!sel.grant && sel.pending[s]
            && lvl_of(sel.high_bits, sel.low_bits, s) == 2'(lv)
            && (!sel.in_service || 2'(lv) > sel.active_level))
        begin
          sel.grant       = 1'b1;
          sel.grant_src   = 3'(s);
          sel.grant_level = 2'(lv);
        end
      end
    end
  end
endmodule

//--- core/iplr_bank.sv
// Priority level register bank for six basic interrupt sources, with a
// Wishbone classic slave and a single-level in-service tracker.
// Assumes request lines arrive from other clock domains or pins.
//
// Function
// - A source's level is its high bit as MSB and low bit as LSB, 0..3.
// - Reset clears the six level bits of both registers to level 0.
// - Low register bit 5 is the timer 2 overflow low level bit.
// - Low register bit 4 is the serial port low level bit.
// - Low register bit 3 is the timer 1 overflow low level bit.
// - Low register bit 2 is the second external input low level bit.
// - Low register bit 1 is the timer 0 overflow low level bit.
// - Low register bit 0 is the first external input low level bit.
// - Only a strictly higher level preempts; level 3 is never preempted.
// - Equal levels are served ext0, tmr0, ext1, tmr1, serial, tmr2.
`include "iplr_consts.svh"
module iplr_bank (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic [31:0]          wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_cyc_i,
  output logic                      wb_ack_o,
  input  wire logic                 external_irq_first_n,
  input  wire logic                 external_irq_second_n,
  input  wire logic                 tmr0_ovf,
  input  wire logic                 tmr1_ovf,
  input  wire logic                 serial_irq,
  input  wire logic                 tmr2_ovf,
  output logic                      irq_req,
  output logic      [2:0]           irq_src,
  output logic      [1:0]           irq_level
);

  ////////////////////////////////////////////////////////////////////////
  iplr_sel_if sel ();
  iplr_resolver u_res (
    .sel (sel)
  );

  iplr_pkg::iplr_vec_t raw_req;
  iplr_pkg::iplr_vec_t sync1_r;
  iplr_pkg::iplr_vec_t sync2_r;
  assign raw_req = {tmr2_ovf, serial_irq, tmr1_ovf,
                    ~external_irq_second_n, tmr0_ovf,
                    ~external_irq_first_n};

  // Two stages; only the second stage feeds any logic.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end
    else
    begin
      sync1_r <= raw_req;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  iplr_pkg::iplr_vec_t high_r;
  iplr_pkg::iplr_vec_t high_nxt;
  iplr_pkg::iplr_vec_t low_r;
  iplr_pkg::iplr_vec_t low_nxt;
  logic [7:0]          ctrl_r;
  logic [7:0]          ctrl_nxt;
  logic                act_r;
  logic                act_nxt;
  logic [1:0]          act_lvl_r;
  logic [1:0]          act_lvl_nxt;
  logic                ack_r;
  logic                ack_nxt;
  logic [31:0]         dat_r;
  logic [31:0]         dat_nxt;
  logic                req_r;
  logic                req_nxt;
  logic [2:0]          src_r;
  logic [2:0]          src_nxt;
  logic [1:0]          lvl_r;
  logic [1:0]          lvl_nxt;
  logic                acc;
  logic                wr0;
  logic [9:0]          word_adr;

  assign sel.high_bits    = high_r;
  assign sel.low_bits     = low_r;
  assign sel.pending      = sync2_r & {6{ctrl_r[`IPLR_CTRL_RUN_BIT]}};
  assign sel.in_service   = act_r;
  assign sel.active_level = act_lvl_r;

  assign acc      = wb_cyc_i && wb_stb_i && !ack_r;
  assign word_adr = {wb_adr_i[9:2], 2'h0};
  assign wr0      = acc && wb_we_i && wb_sel_i[0];

  always_comb
  begin
    high_nxt    = high_r;
    low_nxt     = low_r;
    ctrl_nxt    = ctrl_r;
    act_nxt     = act_r;
    act_lvl_nxt = act_lvl_r;
    ack_nxt     = acc;
    dat_nxt     = 32'h0000_0000;
    // Bits 7:6 are dropped on write, so software zeros there are harmless.
    if (wr0 && word_adr == `IPLR_ADDR_HIGH)
    begin
      high_nxt = wb_dat_i[5:0];
    end
    if (wr0 && word_adr == `IPLR_ADDR_LOW)
    begin
      low_nxt = wb_dat_i[5:0];
    end
    if (wr0 && word_adr == `IPLR_ADDR_CTRL)
    begin
      ctrl_nxt = {6'h00, wb_dat_i[1:0]};
    end
    if (acc && !wb_we_i)
    begin
      unique case (word_adr)
        `IPLR_ADDR_HIGH:   dat_nxt = {26'h0, high_r};
        `IPLR_ADDR_LOW:    dat_nxt = {26'h0, low_r};
        `IPLR_ADDR_CTRL:   dat_nxt = {24'h0, ctrl_r};
        `IPLR_ADDR_STATUS: dat_nxt = {18'h0, sync2_r, 1'b0, src_r,
                                      act_lvl_r, act_r, req_r};
        default:           dat_nxt = 32'h0000_0000;
      endcase
    end
    // A return pulse closes the handler; a grant opens a nested one.
    if (ctrl_r[`IPLR_CTRL_RET_BIT])
    begin
      act_nxt             = 1'b0;
      ctrl_nxt[`IPLR_CTRL_RET_BIT] = 1'b0;
    end
    if (sel.grant)
    begin
      act_nxt     = 1'b1;
      act_lvl_nxt = sel.grant_level;
    end
    req_nxt = sel.grant;
    src_nxt = sel.grant ? sel.grant_src : src_r;
    lvl_nxt = sel.grant ? sel.grant_level : lvl_r;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_r    <= `IPLR_RESET_FIELD;
      low_r     <= `IPLR_RESET_FIELD;
      ctrl_r    <= `IPLR_RESET_CTRL;
      act_r     <= 1'b0;
      act_lvl_r <= 2'h0;
      ack_r     <= 1'b0;
      dat_r     <= 32'h0000_0000;
      req_r     <= 1'b0;
      src_r     <= `IPLR_NONE_ID;
      lvl_r     <= 2'h0;
    end
    else
    begin
      high_r    <= high_nxt;
      low_r     <= low_nxt;
      ctrl_r    <= ctrl_nxt;
      act_r     <= act_nxt;
      act_lvl_r <= act_lvl_nxt;
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
      req_r     <= req_nxt;
      src_r     <= src_nxt;
      lvl_r     <= lvl_nxt;
    end
  end

  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;
  assign irq_req   = req_r;
  assign irq_src   = src_r;
  assign irq_level = lvl_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks. Nesting is a single in-service slot, a deliberate trade of
  // full stack depth for size; the return pulse clears it.
  property p_reset_zero;
    @(posedge core_clk) $rose(rst_n) |-> high_r == 6'h00 && low_r == 6'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("level bits not cleared at reset");

  property p_level_form;
    @(posedge core_clk) disable iff (!rst_n)
    sel.grant |-> sel.grant_level ==
      {high_r[sel.grant_src], low_r[sel.grant_src]};
  endproperty
  a_level_form: assert property (p_level_form)
    else $error("granted level does not match bit pair");

  property p_low_write;
    @(posedge core_clk) disable iff (!rst_n)
    wr0 && word_adr == `IPLR_ADDR_LOW |=> low_r == $past(wb_dat_i[5:0]);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low register write lost");

  property p_high_write;
    @(posedge core_clk) disable iff (!rst_n)
    wr0 && word_adr == `IPLR_ADDR_HIGH |=> high_r == $past(wb_dat_i[5:0]);
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("high register write lost");

  property p_no_preempt;
    @(posedge core_clk) disable iff (!rst_n)
    sel.grant && act_r |-> sel.grant_level > act_lvl_r;
  endproperty
  a_no_preempt: assert property (p_no_preempt)
    else $error("preemption at equal or lower level");

  property p_top_hold;
    @(posedge core_clk) disable iff (!rst_n)
    act_r && act_lvl_r == 2'h3 && !ctrl_r[1] |=> act_lvl_r == 2'h3;
  endproperty
  a_top_hold: assert property (p_top_hold)
    else $error("level 3 handler preempted");

  // Per-source flags for the ordering checks, one pair per source.
  logic [5:0] above_grant;
  logic [5:0] tie_before;
  for (genvar i = 0; i < `IPLR_NSRC; i++)
  begin : g_chk
    assign above_grant[i] = sel.pending[i]
      && {high_r[i], low_r[i]} > sel.grant_level;
    assign tie_before[i]  = sel.pending[i] && 3'(i) < sel.grant_src
      && {high_r[i], low_r[i]} == sel.grant_level;
  end

  property p_order;
    @(posedge core_clk) disable iff (!rst_n)
    sel.grant |-> above_grant == 6'h00;
  endproperty
  a_order: assert property (p_order)
    else $error("lower level served before a higher one");

  property p_tie;
    @(posedge core_clk) disable iff (!rst_n)
    sel.grant |-> tie_before == 6'h00;
  endproperty
  a_tie: assert property (p_tie)
    else $error("equal level source served out of order");

  property p_fixed_order;
    @(posedge core_clk) disable iff (!rst_n)
    sel.grant && sel.grant_src != 3'h0 && !act_r |->
      !(sel.pending[0] && {high_r[0], low_r[0]} == sel.grant_level);
  endproperty
  a_fixed_order: assert property (p_fixed_order)
    else $error("first external input skipped at equal level");

  property p_req_follows;
    @(posedge core_clk) disable iff (!rst_n)
    sel.grant |=> irq_req && irq_src == $past(sel.grant_src);
  endproperty
  a_req_follows: assert property (p_req_follows)
    else $error("grant not reported");

  property p_ack_once;
    @(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held over two cycles");

  property p_ack_follow;
    @(posedge core_clk) disable iff (!rst_n)
    acc |=> wb_ack_o;
  endproperty
  a_ack_follow: assert property (p_ack_follow)
    else $error("bus cycle taken but not acknowledged");

  property p_run_gate;
    @(posedge core_clk) disable iff (!rst_n)
    !ctrl_r[`IPLR_CTRL_RUN_BIT] |-> !sel.grant;
  endproperty
  a_run_gate: assert property (p_run_gate)
    else $error("grant while run bit is clear");

  // A grant in the return cycle wins, so it is left out here.
  property p_ret_clear;
    @(posedge core_clk) disable iff (!rst_n)
    ctrl_r[`IPLR_CTRL_RET_BIT] && !sel.grant |=> !act_r;
  endproperty
  a_ret_clear: assert property (p_ret_clear)
    else $error("return pulse did not close the handler");

  c_grant: cover property (@(posedge core_clk) sel.grant);
  c_nest: cover property (@(posedge core_clk) sel.grant && act_r);
  c_ret: cover property (@(posedge core_clk)
    ctrl_r[`IPLR_CTRL_RET_BIT] && act_r);
  c_top: cover property (@(posedge core_clk)
    sel.grant && sel.grant_level == 2'h3);
endmodule

//--- bench/iplr_src_model.sv
// Model of the six request sources beside the priority bank.
// Assumes the bench gives one active-high request bit per source id.
module iplr_src_model (
  input  wire logic [5:0] req,
  output logic            ext0_n,
  output logic            tmr0,
  output logic            ext1_n,
  output logic            tmr1,
  output logic            ser,
  output logic            tmr2
);
  timeunit 1ns;
  timeprecision 1ps;
  // The external pins idle high, so a request pulls them low.
  assign ext0_n = ~req[0];
  assign tmr0   = req[1];
  assign ext1_n = ~req[2];
  assign tmr1   = req[3];
  assign ser    = req[4];
  assign tmr2   = req[5];
endmodule

//--- bench/iplr_bank_tb.sv
// Self-checking bench for the priority bank over Wishbone.
// Assumes the bank answers each bus cycle and grants within a few edges.
`include "iplr_consts.svh"
module iplr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_we_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_ack_o;
  logic [5:0]  req = 6'h00;
  logic [5:0]  pin;
  logic        irq_req;
  logic [2:0]  irq_src;
  logic [1:0]  irq_level;
  logic [31:0] rd;
  bit          g;
  int          fail_count = 0;
  int          n_checks = 0;
  int          lvl [6];

  always #5 core_clk = ~core_clk;

  iplr_src_model u_iplr_src_model (.req(req), .ext0_n(pin[0]),
    .tmr0(pin[1]), .ext1_n(pin[2]), .tmr1(pin[3]), .ser(pin[4]),
    .tmr2(pin[5]));

  iplr_bank u_iplr_bank (.core_clk(core_clk), .rst_n(rst_n),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(4'hf), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
    .external_irq_first_n(pin[0]), .tmr0_ovf(pin[1]),
    .external_irq_second_n(pin[2]), .tmr1_ovf(pin[3]),
    .serial_irq(pin[4]), .tmr2_ovf(pin[5]), .irq_req(irq_req),
    .irq_src(irq_src), .irq_level(irq_level));

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic chk_grant(string nm, logic [5:0] e, logic [5:0] s);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask

  // Called just after a rising edge; holds the request until the rising
  // edge at which ack is sampled high, takes read data there, releases
  // and then keeps the bus idle for one cycle.
  task automatic wb(logic we, logic [9:0] a, logic [31:0] d);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {22'h0, a};
    wb_dat_i <= d;
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1)
    begin
      fail_count++;
      wrap_up();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wait_grant();
    g = 1'b0;
    for (int i = 0; i < 12 && !g; i++)
    begin
      @(negedge core_clk);
      g = (irq_req === 1'b1);
    end
    @(posedge core_clk);
  endtask

  // Reference: highest level wins, lowest source id breaks a tie.
  function automatic int best(logic [5:0] m);
    int b = 0;
    for (int s = 5; s >= 0; s--)
      if (m[s] && lvl[s] >= lvl[b] || !m[b])
        b = s;
    return b;
  endfunction

  task automatic trial(logic [5:0] hi, logic [5:0] lo, logic [5:0] m);
    int b;
    for (int s = 0; s < 6; s++)
      lvl[s] = 2 * hi[s] + lo[s];
    wb(1'b1, `IPLR_ADDR_HIGH, {26'h0, hi});
    wb(1'b1, `IPLR_ADDR_LOW, {26'h0, lo});
    wb(1'b0, `IPLR_ADDR_LOW, 32'h0);
    chk_reg("low", {26'h0, lo}, rd);
    wb(1'b0, `IPLR_ADDR_HIGH, 32'h0);
    chk_reg("high", {26'h0, hi}, rd);
    b = best(m);
    req <= m;
    wait_grant();
    chk_grant("grant", {1'b1, 3'(b), 2'(lvl[b])}, {g, irq_src, irq_level});
    req <= 6'h00;
    repeat (5) @(posedge core_clk);
    wb(1'b1, `IPLR_ADDR_CTRL, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h0dff2471));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    wb(1'b0, `IPLR_ADDR_HIGH, 32'h0);
    chk_reg("high", 32'h0, rd);
    wb(1'b0, `IPLR_ADDR_LOW, 32'h0);
    chk_reg("low", 32'h0, rd);
    wb(1'b0, 10'h040, 32'h0);
    chk_reg("unmapped", 32'h0, rd);
    wb(1'b1, `IPLR_ADDR_CTRL, 32'h1);
    for (int s = 0; s < 6; s++)
    begin
      trial(6'h00, 6'h01 << s, 6'h3f);
      trial(6'h01 << s, 6'h00, 6'h3f);
    end
    repeat (16)
      trial(6'($urandom), 6'($urandom), 6'($urandom % 63) + 6'h01);
    wb(1'b1, `IPLR_ADDR_HIGH, 32'h20);
    wb(1'b1, `IPLR_ADDR_LOW, 32'h23);
    req <= 6'h01;
    wait_grant();
    chk_grant("first", 6'h21, {g, irq_src, irq_level});
    req <= 6'h03;
    wait_grant();
    chk_grant("equal", 6'h01, {g, irq_src, irq_level});
    req <= 6'h23;
    wait_grant();
    chk_grant("higher", 6'h37, {g, irq_src, irq_level});
    req <= 6'h00;
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk_grant("reset out", 6'h1c, {irq_req, irq_src, irq_level});
    rst_n <= 1'b1;
    @(posedge core_clk);
    wb(1'b0, `IPLR_ADDR_HIGH, 32'h0);
    chk_reg("high again", 32'h0, rd);
    wb(1'b0, `IPLR_ADDR_LOW, 32'h0);
    chk_reg("low again", 32'h0, rd);
    wrap_up();
  end
endmodule
